// ==== verilog/vat_trap_top.sv ====
// VGA memory and I/O access trap with AHB-Lite register slave and SMI output
//
// Summary of operation
// - Control bit 0 set traps every enabled access to A0000h-AFFFFh.
// - Control bit 1 set traps accesses to B0000h-B7FFFh.
// - Control bit 2 set traps accesses to B8000h-BFFFFh.
// - Control register resets to zero so nothing traps until enabled.
// - Region mask holds 32 enables, one per 2 KB slice of A window.
// - Mask bit n covers A0000h plus n times 800h; one enables.
// - With no window enabled the region mask has no effect.
// - I/O ranges 3B0h, 3C0h, 3D0h each trap under their own enable bit.
// - SMI is raised in the same cycle the trapped access is seen.
// - Detection uses translated physical address from second decode stage.
//
// Register map, byte address four times the register index:
//   2E4h  window trap control
//         bit 0 A0000h-AFFFFh, bit 1 B0000h-B7FFFh, bit 2 B8000h-BFFFFh
//         bits 7:3 stored and read back, no effect on trapping
//   2E8h  region trap mask, bit n enables the 2 KB slice at A0000h + n*800h
//   300h  I/O range enables, bit 0 3B0h-3BFh, bit 1 3C0h-3CFh, bit 2 3D0h-3DFh
//   304h  trap status, bit 0 memory, bit 1 I/O, write one to clear
//   308h  interrupt mask, same layout as status
//   30Ch  last trapped address, read only, I/O ports zero-extended
// Only haddr 9:0 is decoded, so the map aliases every 1 KB of bus space.
// Unmapped offsets read zero and drop writes; the slave never stalls.
// Access inputs share the core clock, so they pass no synchroniser.
// Timing: smi_req rises in the cycle of the trapped access itself; status and
// the trapped address update at the end of that cycle, irq rises with status.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module vat_trap_top
    import vat_pkg::*;
(
    input  wire logic        hclk,        // Core clock, 200 MHz
    input  wire logic        hresetn,     // Async reset, active low
    input  wire logic        hsel,        // AHB slave select
    input  wire logic [31:0] haddr,       // AHB address
    input  wire logic [1:0]  htrans,      // AHB transfer type
    input  wire logic        hwrite,      // AHB write flag
    input  wire logic [2:0]  hsize,       // AHB size, word only
    input  wire logic [31:0] hwdata,      // AHB write data
    input  wire logic        hready,      // AHB bus ready
    output logic [31:0]      hrdata,      // AHB read data, registered
    output logic             hreadyout,   // Always ready
    output logic             hresp,       // Always OKAY
    input  wire logic        acc_valid,   // Decode stage 2 access valid
    input  wire logic        acc_is_io,   // Access is an I/O cycle
    input  wire logic [31:0] acc_paddr,   // Physical memory address
    input  wire logic [15:0] acc_io_addr, // I/O port address
    output logic             smi_req,     // SMI request pulse
    output logic             irq          // Level interrupt
);
    // Registers
    logic [7:0]  ctrl_ff;
    logic [31:0] mask_ff;
    logic [2:0]  iomap_ff;
    logic [1:0]  status_ff;
    logic [1:0]  irqmask_ff;
    logic [31:0] trapaddr_ff;
    logic [31:0] hrdata_ff;
    logic        wr_pend_ff;
    logic [VAT_ADDR_W-1:0] wr_addr_ff;

    // Next values and decodes
    logic [7:0]  nxt_ctrl;
    logic [31:0] nxt_mask;
    logic [2:0]  nxt_iomap;
    logic [1:0]  nxt_irqmask;
    logic [31:0] nxt_hrdata;
    logic [1:0]  st_clr;
    logic [1:0]  st_set;
    logic        addr_phase;
    logic        rd_phase;
    logic        hit_a;
    logic        hit_b0;
    logic        hit_b8;
    logic        slice_on;
    logic        mem_trap;
    logic        io_trap;
    logic [2:0]  io_hit;
    logic        wr_phase;
    logic        wr_ctrl;
    logic        wr_mask;
    logic        wr_iomap;
    logic        wr_status;
    logic        wr_irqmask;
    logic        mem_acc;
    logic        io_acc;
    logic        trap_a;
    logic        trap_b0;
    logic        trap_b8;
    logic [1:0]  nxt_status;
    logic [31:0] nxt_trapaddr;

    // I/O range tags packed in enable-bit order, so enable n meets tag n
    localparam int IO_RANGES = 3;
    localparam int IO_TAG_W  = 12;
    localparam logic [IO_RANGES*IO_TAG_W-1:0] IO_TAGS =
        {VAT_IO_3D_TAG, VAT_IO_3C_TAG, VAT_IO_3B_TAG};

    // AHB slave never stalls and never errors
    // Zero wait states: hrdata is ready one cycle after the address phase
    assign hreadyout = 1'b1;
    assign hresp     = VAT_HRESP_OKAY;
    assign hrdata    = hrdata_ff;

    // Address phase taken when selected, NONSEQ and bus ready
    assign addr_phase = hsel && hready && (htrans == VAT_HTRANS_NONSEQ);

    // Reads load hrdata at the address edge; writes wait a cycle for hwdata
    assign rd_phase   = addr_phase && !hwrite;
    assign wr_phase   = addr_phase && hwrite;

    // Data-phase flag of a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
        end else begin
            wr_pend_ff <= wr_phase;
        end
    end

    // Write address held into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_ff <= '0;
        end else if (wr_phase) begin
            wr_addr_ff <= haddr[VAT_ADDR_W-1:0];
        end
    end

    // One write strobe per writable register; an unmapped or read-only offset raises none
    assign wr_ctrl    = wr_pend_ff && (wr_addr_ff == VAT_ADDR_CTRL);
    assign wr_mask    = wr_pend_ff && (wr_addr_ff == VAT_ADDR_MASK);
    assign wr_iomap   = wr_pend_ff && (wr_addr_ff == VAT_ADDR_IOMAP);
    assign wr_status  = wr_pend_ff && (wr_addr_ff == VAT_ADDR_STATUS);
    assign wr_irqmask = wr_pend_ff && (wr_addr_ff == VAT_ADDR_IRQMASK);

    // Next register values from a write in its data phase
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_mask    = mask_ff;
        nxt_iomap   = iomap_ff;
        nxt_irqmask = irqmask_ff;
        st_clr      = 2'h0;
        if (wr_ctrl) begin
            nxt_ctrl = hwdata[7:0];
        end
        if (wr_mask) begin
            nxt_mask = hwdata;
        end
        if (wr_iomap) begin
            nxt_iomap = hwdata[2:0];
        end
        if (wr_irqmask) begin
            nxt_irqmask = hwdata[1:0];
        end
        if (wr_status) begin
            st_clr = hwdata[1:0]; // Write one to clear
        end
    end

    // Control register, cleared so an add-in VGA card works untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= VAT_CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Region mask; given a defined reset value for clean simulation
    // Trapping stays off after reset anyway, since every window enable is clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_ff <= VAT_MASK_RST;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // I/O range enables, one bit per 16-port range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iomap_ff <= VAT_IOMAP_RST;
        end else begin
            iomap_ff <= nxt_iomap;
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqmask_ff <= VAT_IRQMASK_RST;
        end else begin
            irqmask_ff <= nxt_irqmask;
        end
    end

    // Read data uses next values so a read right after a write sees it
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        case (haddr[VAT_ADDR_W-1:0])
            VAT_ADDR_CTRL:     nxt_hrdata = {24'h000000, nxt_ctrl};
            VAT_ADDR_MASK:     nxt_hrdata = nxt_mask;
            VAT_ADDR_IOMAP:    nxt_hrdata = {29'h0, nxt_iomap};
            VAT_ADDR_STATUS:   nxt_hrdata = {30'h0, nxt_status};
            VAT_ADDR_IRQMASK:  nxt_hrdata = {30'h0, nxt_irqmask};
            VAT_ADDR_TRAPADDR: nxt_hrdata = trapaddr_ff;
            default:           nxt_hrdata = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded at the address phase edge;
    // it holds until the next read, so a late sample still sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_phase) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Window and slice decode on the translated address
    vat_window_decode u_decode (
        .phys_addr   (acc_paddr),
        .region_mask (mask_ff),
        .hit_a       (hit_a),
        .hit_b0      (hit_b0),
        .hit_b8      (hit_b8),
        .slice_on    (slice_on)
    );

    // The access flag splits memory from I/O, so one kind traps per cycle
    assign mem_acc = acc_valid && !acc_is_io;
    assign io_acc  = acc_valid && acc_is_io;

    // Per-window terms; the mask is only consulted under the A enable
    assign trap_a  = ctrl_ff[VAT_CTRL_A_BIT] && hit_a && slice_on;
    assign trap_b0 = ctrl_ff[VAT_CTRL_B0_BIT] && hit_b0;
    assign trap_b8 = ctrl_ff[VAT_CTRL_B8_BIT] && hit_b8;

    // Memory trap from any enabled window
    assign mem_trap = mem_acc && (trap_a || trap_b0 || trap_b8);

    // I/O range compare, one per 16-port range, tag n under enable bit n
    genvar gi;
    generate
        for (gi = 0; gi < IO_RANGES; gi = gi + 1) begin : g_io
            assign io_hit[gi] =
                (acc_io_addr[15:4] == IO_TAGS[gi*IO_TAG_W +: IO_TAG_W]);
        end
    endgenerate

    // I/O range trap under its own enable bit
    assign io_trap = io_acc && |(io_hit & iomap_ff);

    // Combinational so the trap lands before buffered writes retire
    assign smi_req = mem_trap || io_trap;

    // Next trapping address; I/O ports are zero-extended into the same register
    always_comb begin
        nxt_trapaddr = trapaddr_ff;
        if (mem_trap) begin
            nxt_trapaddr = acc_paddr;
        end else if (io_trap) begin
            nxt_trapaddr = {16'h0000, acc_io_addr};
        end
    end

    // Last trapping address for the handler; only the latest event is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trapaddr_ff <= VAT_TRAPADDR_RST;
        end else begin
            trapaddr_ff <= nxt_trapaddr;
        end
    end

    // Sticky status, a new event wins over a same-cycle clear
    assign st_set     = {io_trap, mem_trap};
    assign nxt_status = (status_ff & ~st_clr) | st_set;

    // Status register; software clears a bit by writing one to it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= VAT_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Level interrupt while any unmasked status bit stands
    assign irq = |(status_ff & irqmask_ff);

    // AHB size is not decoded: every access is taken as a whole word, so a
    // narrow write replaces the full register; drivers must use word size
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule
`default_nettype wire

// ==== inc/vat_pkg.sv ====
// Package with register map, field positions and window constants for the VGA access trap
package vat_pkg;
    // Printed register indexes; byte address is four times the index
    localparam logic [7:0]  VAT_IDX_CTRL      = 8'hB9;
    localparam logic [7:0]  VAT_IDX_MASK      = 8'hBA;
    localparam logic [7:0]  VAT_IDX_IOMAP     = 8'hC0;
    localparam logic [7:0]  VAT_IDX_STATUS    = 8'hC1;
    localparam logic [7:0]  VAT_IDX_IRQMASK   = 8'hC2;
    localparam logic [7:0]  VAT_IDX_TRAPADDR  = 8'hC3;
    localparam logic [9:0]  VAT_ADDR_CTRL     = {VAT_IDX_CTRL, 2'b00};
    localparam logic [9:0]  VAT_ADDR_MASK     = {VAT_IDX_MASK, 2'b00};
    localparam logic [9:0]  VAT_ADDR_IOMAP    = {VAT_IDX_IOMAP, 2'b00};
    localparam logic [9:0]  VAT_ADDR_STATUS   = {VAT_IDX_STATUS, 2'b00};
    localparam logic [9:0]  VAT_ADDR_IRQMASK  = {VAT_IDX_IRQMASK, 2'b00};
    localparam logic [9:0]  VAT_ADDR_TRAPADDR = {VAT_IDX_TRAPADDR, 2'b00};
    localparam int          VAT_ADDR_W        = 10;

    // Reset values
    localparam logic [7:0]  VAT_CTRL_RST      = 8'h00;
    localparam logic [31:0] VAT_MASK_RST      = 32'h0000_0000;
    localparam logic [2:0]  VAT_IOMAP_RST     = 3'h0;
    localparam logic [1:0]  VAT_STATUS_RST    = 2'h0;
    localparam logic [1:0]  VAT_IRQMASK_RST   = 2'h0;
    localparam logic [31:0] VAT_TRAPADDR_RST  = 32'h0000_0000;

    // Control register fields
    localparam int          VAT_CTRL_A_BIT    = 0;
    localparam int          VAT_CTRL_B0_BIT   = 1;
    localparam int          VAT_CTRL_B8_BIT   = 2;

    // Status and irq mask fields
    localparam int          VAT_ST_MEM_BIT    = 0;
    localparam int          VAT_ST_IO_BIT     = 1;

    // Memory windows, compared on physical address
    localparam logic [15:0] VAT_WIN_A_TAG     = 16'h000A;
    localparam logic [16:0] VAT_WIN_B0_TAG    = 17'h00016;
    localparam logic [16:0] VAT_WIN_B8_TAG    = 17'h00017;
    localparam int          VAT_SLICE_HI      = 15;
    localparam int          VAT_SLICE_LO      = 11;
    localparam int          VAT_SLICES        = 32;

    // I/O ranges, compared on port address bits 15:4
    localparam logic [11:0] VAT_IO_3B_TAG     = 12'h03B;
    localparam logic [11:0] VAT_IO_3C_TAG     = 12'h03C;
    localparam logic [11:0] VAT_IO_3D_TAG     = 12'h03D;

    // AHB encodings
    localparam logic [1:0]  VAT_HTRANS_NONSEQ = 2'h2;
    localparam logic        VAT_HRESP_OKAY    = 1'b0;
endpackage

// ==== verilog/vat_window_decode.sv ====
// Physical address window and slice decoder for the VGA access trap
`timescale 1ns/1ps
`default_nettype none
module vat_window_decode
    import vat_pkg::*;
(
    input  wire logic [31:0] phys_addr,   // Translated access address
    input  wire logic [31:0] region_mask, // Per-slice enables of the A window
    output logic             hit_a,       // Address in A0000h-AFFFFh
    output logic             hit_b0,      // Address in B0000h-B7FFFh
    output logic             hit_b8,      // Address in B8000h-BFFFFh
    output logic             slice_on     // A-window slice enabled in mask
);
    logic [VAT_SLICES-1:0] slice_sel;

    // Window compares on full physical address, so aliases above 1 MB never trap
    assign hit_a  = (phys_addr[31:16] == VAT_WIN_A_TAG);
    assign hit_b0 = (phys_addr[31:15] == VAT_WIN_B0_TAG);
    assign hit_b8 = (phys_addr[31:15] == VAT_WIN_B8_TAG);

    // One select per 2 KB slice, bit n at A0000h plus n times 800h
    genvar gi;
    generate
        for (gi = 0; gi < VAT_SLICES; gi = gi + 1) begin : g_slice
            assign slice_sel[gi] = hit_a &&
                (phys_addr[VAT_SLICE_HI:VAT_SLICE_LO] == 5'(gi));
        end
    endgenerate

    // Mask only gates the A window
    assign slice_on = |(slice_sel & region_mask);
endmodule
`default_nettype wire

// ==== tb/vat_trap_chk.sv ====
// Port checker for the VGA access trap
`timescale 1ns/1ps
`default_nettype none
module vat_trap_chk
    import vat_pkg::*;
(
    input wire logic        hclk,        // Clock
    input wire logic        hresetn,     // Reset
    input wire logic        hsel,        // Select
    input wire logic [31:0] haddr,       // Address
    input wire logic [1:0]  htrans,      // Type
    input wire logic        hwrite,      // Write
    input wire logic [31:0] hwdata,      // Wdata
    input wire logic        hready,      // Ready
    input wire logic [31:0] hrdata,      // Rdata
    input wire logic        acc_valid,   // Access
    input wire logic        acc_is_io,   // I/O
    input wire logic [31:0] acc_paddr,   // Address
    input wire logic [15:0] acc_io_addr, // Port
    input wire logic        smi_req      // Trap
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        wr_ff;
    logic        rd_ff;
    logic [9:0]  adr_ff;
    logic [7:0]  ctl_ff;
    logic [31:0] msk_ff;
    logic [2:0]  iom_ff;
    logic        mem;
    logic        io_exp;
    // Shadow of the enables, so a trap can be predicted from the ports alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            adr_ff <= 10'h000;
            ctl_ff <= 8'h00;
            msk_ff <= 32'h0000_0000;
            iom_ff <= 3'h0;
        end else begin
            wr_ff  <= hsel && hready && htrans == VAT_HTRANS_NONSEQ && hwrite;
            rd_ff  <= hsel && hready && htrans == VAT_HTRANS_NONSEQ && !hwrite;
            adr_ff <= haddr[9:0];
            if (wr_ff && adr_ff == VAT_ADDR_CTRL) ctl_ff <= hwdata[7:0];
            if (wr_ff && adr_ff == VAT_ADDR_MASK) msk_ff <= hwdata;
            if (wr_ff && adr_ff == VAT_ADDR_IOMAP) iom_ff <= hwdata[2:0];
        end
    end
    // Expected trap terms
    assign mem = acc_valid && !acc_is_io;
    assign io_exp = (acc_io_addr[15:4] == VAT_IO_3B_TAG && iom_ff[0])
        || (acc_io_addr[15:4] == VAT_IO_3C_TAG && iom_ff[1])
        || (acc_io_addr[15:4] == VAT_IO_3D_TAG && iom_ff[2]);
    win_a_a:
        assert property (mem && acc_paddr[31:16] == VAT_WIN_A_TAG && ctl_ff[0]
            && msk_ff[acc_paddr[15:11]] |-> smi_req) else $error("A access missed");
    slice_off_a:
        assert property (mem && acc_paddr[31:16] == VAT_WIN_A_TAG
            && !msk_ff[acc_paddr[15:11]] |-> !smi_req) else $error("Masked slice trapped");
    win_b0_a:
        assert property (mem && acc_paddr[31:15] == VAT_WIN_B0_TAG |-> smi_req == ctl_ff[1])
            else $error("B0 trap wrong");
    win_b8_a:
        assert property (mem && acc_paddr[31:15] == VAT_WIN_B8_TAG |-> smi_req == ctl_ff[2])
            else $error("B8 trap wrong");
    all_off_a:
        assert property (mem && ctl_ff[2:0] == 3'h0 |-> !smi_req) else $error("Trap while off");
    io_trap_a:
        assert property (acc_valid && acc_is_io |-> smi_req == io_exp) else $error("I/O trap wrong");
    no_access_a:
        assert property (acc_valid ##1 !acc_valid |-> !smi_req) else $error("Trap after access");
    ctl_read_a:
        assert property (rd_ff && adr_ff == VAT_ADDR_CTRL |-> hrdata == {24'h000000, ctl_ff})
            else $error("Control readback wrong");
    cover property (mem && smi_req);
    cover property (acc_is_io && smi_req);
    cover property (rd_ff && adr_ff == VAT_ADDR_CTRL);
endmodule
bind vat_trap_top vat_trap_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .acc_valid(acc_valid), .acc_is_io(acc_is_io), .acc_paddr(acc_paddr),
    .acc_io_addr(acc_io_addr), .smi_req(smi_req));
`default_nettype wire

// ==== tb/vat_cpu_model.sv ====
// Decode-stage access source standing in for the core
`timescale 1ns/1ps
`default_nettype none
module vat_cpu_model (
    input  wire logic       hclk,                 // Clock
    output var logic        acc_valid = 1'b0,     // Strobe
    output var logic        acc_is_io = 1'b0,     // I/O flag
    output var logic [31:0] acc_paddr = 32'h0,    // Address
    output var logic [15:0] acc_io_addr = 16'h0   // Port
);
    // One access for one cycle, address already translated
    task automatic issue(input logic io, input logic [31:0] a);
        @(posedge hclk);
        acc_valid   <= 1'b1;
        acc_is_io   <= io;
        acc_paddr   <= a;
        acc_io_addr <= a[15:0];
    endtask
    // Idle lines flip, so a stale address cannot pass for a live one
    task automatic drop();
        @(posedge hclk);
        acc_valid   <= 1'b0;
        acc_paddr   <= ~acc_paddr;
        acc_io_addr <= ~acc_io_addr;
    endtask
endmodule
`default_nettype wire

// ==== tb/vga_access_smi_trap_tb.sv ====
// Self-checking bench for the VGA access trap
`timescale 1ns/1ps
`default_nettype none
module vga_access_smi_trap_tb;
    import vat_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] d;
    logic        hreadyout, hresp, smi_req, irq, acc_valid, acc_is_io;
    logic [31:0] acc_paddr;
    logic [15:0] acc_io_addr;
    int          n_fail = 0;
    int          tests_run = 0;
    // Control, expected trap, address; mask is zero here
    logic [40:0] tbl [0:9] = '{{8'h01, 1'b0, 32'h000B_0000}, {8'h02, 1'b1, 32'h000B_0000},
        {8'h02, 1'b1, 32'h000B_7FFF}, {8'h02, 1'b0, 32'h000B_8000},
        {8'h04, 1'b1, 32'h000B_8000}, {8'h04, 1'b1, 32'h000B_FFFF},
        {8'h04, 1'b0, 32'h000B_7FFF}, {8'h07, 1'b0, 32'h000A_0000},
        {8'h07, 1'b0, 32'h100B_0000}, {8'h07, 1'b1, 32'h000B_0000}};
    vat_trap_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid),
        .acc_is_io(acc_is_io), .acc_paddr(acc_paddr), .acc_io_addr(acc_io_addr),
        .smi_req(smi_req), .irq(irq));
    vat_cpu_model u_cpu (.hclk(hclk), .acc_valid(acc_valid), .acc_is_io(acc_is_io),
        .acc_paddr(acc_paddr), .acc_io_addr(acc_io_addr));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bounded wait for ready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // One single word transfer; read data lands in d
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= VAT_HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= {22'h0, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        d = hrdata;
        chk("hresp", {31'h0, hresp}, {31'h0, VAT_HRESP_OKAY});
    endtask
    task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, d, e);
    endtask
    // Trap is combinational, so look just after the launching edge
    task automatic acc(input logic io, input logic [31:0] a, input logic e);
        u_cpu.issue(io, a);
        #1;
        chk("smi", {31'h0, smi_req}, {31'h0, e});
        u_cpu.drop();
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("ctrl", VAT_ADDR_CTRL, 32'h0);
        rd("hole", 10'h3FC, 32'h0);
        bus(1'b1, VAT_ADDR_MASK, 32'hFFFF_FFFF);
        acc(1'b0, 32'h000A_0000, 1'b0);
        acc(1'b0, 32'h000B_8000, 1'b0);
        bus(1'b1, VAT_ADDR_CTRL, 32'h0000_00F9);
        rd("ctrl", VAT_ADDR_CTRL, 32'h0000_00F9);
        bus(1'b1, VAT_ADDR_MASK, 32'h8000_0002);
        rd("mask", VAT_ADDR_MASK, 32'h8000_0002);
        for (int n = 0; n < 32; n++) begin
            acc(1'b0, 32'h000A_0000 + n * 32'h800, n == 1 || n == 31);
            acc(1'b0, 32'h000A_07FF + n * 32'h800, n == 1 || n == 31);
        end
        bus(1'b1, VAT_ADDR_MASK, 32'h0);
        foreach (tbl[i]) begin
            bus(1'b1, VAT_ADDR_CTRL, {24'h0, tbl[i][40:33]});
            acc(1'b0, tbl[i][31:0], tbl[i][32]);
        end
        bus(1'b1, VAT_ADDR_IOMAP, 32'h5);
        acc(1'b1, 32'h3B0, 1'b1);
        acc(1'b1, 32'h3CF, 1'b0);
        acc(1'b1, 32'h3DF, 1'b1);
        acc(1'b1, 32'h000B_0000, 1'b0);
        // Sticky event: held while masked, then unmasked and cleared
        bus(1'b1, VAT_ADDR_STATUS, 32'h3);
        acc(1'b0, 32'h000B_0004, 1'b1);
        rd("addr", VAT_ADDR_TRAPADDR, 32'h000B_0004);
        rd("stat", VAT_ADDR_STATUS, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        bus(1'b1, VAT_ADDR_IRQMASK, 32'h1);
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        bus(1'b1, VAT_ADDR_STATUS, 32'h1);
        #1;
        chk("irq", {31'h0, irq}, 32'h0);
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge hclk);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
